// ### hw/sync_meas_pkg.sv
// constants for the sync bypass and sync measurement block
// assumes a 250 MHz system clock and a byte-wide host register port
package sync_meas_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ADDR_PASSTHROUGH_CTL = 8'h36;
  localparam logic [7:0] ADDR_FRAME_LINES_LO = 8'h37;
  localparam logic [7:0] ADDR_FRAME_LINES_HI = 8'h38;
  localparam logic [7:0] ADDR_LINE_CLOCKS_LO = 8'h39;
  localparam logic [7:0] ADDR_LINE_CLOCKS_HI = 8'h3A;
  localparam logic [7:0] ADDR_HSYNC_LENGTH = 8'h3B;
  localparam logic [7:0] ADDR_VSYNC_LENGTH = 8'h3C;
  localparam logic [7:0] ADDR_LINE_TOLERANCE = 8'h3D;
  localparam logic [7:0] ADDR_RESERVED_FIXED = 8'h3E;
  localparam logic [7:0] ADDR_BANDWIDTH_CTL = 8'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int BIT_HORIZ_PASS = 0;
  localparam int BIT_VERT_PASS = 1;
  localparam int BIT_HORIZ_INV = 2;
  localparam int BIT_VERT_INV = 3;
  localparam int BIT_PROGRESSIVE = 5;
  localparam int BIT_PSEUDO_SYNC = 6;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [3:0] RST_PASSTHROUGH_CTL = 4'h0;
  localparam logic [6:0] RST_LINE_TOLERANCE = 7'h03;
  localparam logic [7:0] RST_RESERVED_FIXED = 8'h04;
  localparam logic [3:0] RST_BANDWIDTH_CTL = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam longint SYS_CLK_HZ = 250000000;
  localparam longint INT_REF_HZ = 6500000;
  // internal reference tick period in system cycles, rounded down
  localparam logic [7:0] INT_REF_DIV = 8'(SYS_CLK_HZ / INT_REF_HZ);

endpackage

// ### hw/sync_2ff.sv
// two flip-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level; no bus coherence between bits
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  // first stage is read only by the second stage
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= next_meta;
      sync_o <= next_sync;
    end
  end

endmodule

// ### hw/ref_tick_gen.sv
// measurement reference tick: internal divider or external clock edges
// assumes ext_ref_i is already synchronised to clk_sys_i
`timescale 1ns/1ps
module ref_tick_gen (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic use_external_i,
  input wire logic ext_ref_i,
  output logic tick_o
);

  logic [7:0] div_cnt;
  logic ext_d;
  logic [7:0] next_div_cnt;
  logic next_ext_d;
  logic next_tick;

  // reference select
  always_comb begin
    next_ext_d = ext_ref_i;
    next_div_cnt = div_cnt + 8'h01;
    next_tick = 1'b0;
    if (div_cnt >= sync_meas_pkg::INT_REF_DIV - 8'h01) begin
      next_div_cnt = 8'h00;
      next_tick = ~use_external_i;
    end
    // rising edge of the external reference; up to 27 MHz fits the 2ff path
    if (use_external_i && ext_ref_i && !ext_d) begin
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      div_cnt <= 8'h00;
      ext_d <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ext_d <= next_ext_d;
      tick_o <= next_tick;
    end
  end

endmodule

// ### hw/sync_measure_and_bypass.sv
// sync passthrough and input sync timing measurement
// assumes raw syncs and external reference arrive from pins; processed syncs,
// polarity and reference select come from logic on clk_sys_i
//
// Overview of operation
// - vertical invert acts only in vertical passthrough
// - horizontal invert acts only in horizontal passthrough
// - vertical passthrough outputs raw vertical sync
// - horizontal passthrough outputs raw horizontal sync
// - report twelve bit lines per frame
// - flag pseudo-syncs at bit six
// - report progressive or interlaced at bit five
// - counters run without horizontal PLL lock
// - report longest line length in reference clocks
// - measure against internal or external reference
// - report horizontal sync width in reference clocks
// - report vertical sync width in lines
// - seven bit tolerance steers line measurement
// - four bit bandwidth select for all channels
// - output offset ignored in any passthrough
`timescale 1ns/1ps
module sync_measure_and_bypass (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic hsync_in_i,
  input wire logic vsync_in_i,
  input wire logic external_ref_clock_in_i,
  input wire logic ref_clock_external_i,
  input wire logic hsync_active_high_i,
  input wire logic vsync_active_high_i,
  input wire logic proc_hsync_i,
  input wire logic proc_vsync_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic vert_horiz_output_offset_enable_o,
  output logic [3:0] analog_filter_select_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation and reference tick

  logic [2:0] pins_s;
  logic ref_tick;

  sync_2ff #(.W(3)) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i({external_ref_clock_in_i, vsync_in_i, hsync_in_i}),
    .sync_o(pins_s)
  );

  ref_tick_gen u_ref_tick (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .use_external_i(ref_clock_external_i),
    .ext_ref_i(pins_s[2]),
    .tick_o(ref_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  logic [3:0] ctl;
  logic [6:0] tol;
  logic [7:0] rsv;
  logic [3:0] bw;
  logic [3:0] next_ctl;
  logic [6:0] next_tol;
  logic [7:0] next_rsv;
  logic [3:0] next_bw;

  always_comb begin
    next_ctl = ctl;
    next_tol = tol;
    next_rsv = rsv;
    next_bw = bw;
    if (reg_wr_i) begin
      // status offsets fall through, writes ignored
      unique case (reg_addr_i)
        sync_meas_pkg::ADDR_PASSTHROUGH_CTL: next_ctl = reg_wdata_i[3:0];
        sync_meas_pkg::ADDR_LINE_TOLERANCE: next_tol = reg_wdata_i[6:0];
        // stored as written; software must keep 04h
        sync_meas_pkg::ADDR_RESERVED_FIXED: next_rsv = reg_wdata_i;
        sync_meas_pkg::ADDR_BANDWIDTH_CTL: next_bw = reg_wdata_i[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctl <= sync_meas_pkg::RST_PASSTHROUGH_CTL;
      tol <= sync_meas_pkg::RST_LINE_TOLERANCE;
      rsv <= sync_meas_pkg::RST_RESERVED_FIXED;
      bw <= sync_meas_pkg::RST_BANDWIDTH_CTL;
    end else begin
      ctl <= next_ctl;
      tol <= next_tol;
      rsv <= next_rsv;
      bw <= next_bw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync outputs

  logic next_hsync;
  logic next_vsync;
  logic next_offset_en;

  always_comb begin
    next_hsync = ctl[sync_meas_pkg::BIT_HORIZ_PASS] ?
                 (pins_s[0] ^ ctl[sync_meas_pkg::BIT_HORIZ_INV]) : proc_hsync_i;
    next_vsync = ctl[sync_meas_pkg::BIT_VERT_PASS] ?
                 (pins_s[1] ^ ctl[sync_meas_pkg::BIT_VERT_INV]) : proc_vsync_i;
    next_offset_en = ~(ctl[sync_meas_pkg::BIT_HORIZ_PASS] |
                       ctl[sync_meas_pkg::BIT_VERT_PASS]);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      vert_horiz_output_offset_enable_o <= 1'b1;
      analog_filter_select_o <= sync_meas_pkg::RST_BANDWIDTH_CTL;
    end else begin
      hsync_o <= next_hsync;
      vsync_o <= next_vsync;
      vert_horiz_output_offset_enable_o <= next_offset_en;
      analog_filter_select_o <= bw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement
  // nothing here looks at PLL lock; only the raw syncs, their polarity inputs, the tolerance and the tick

  logic h_act;
  logic v_act;
  logic h_act_d;
  logic v_act_d;
  logic [11:0] line_cnt;
  logic [11:0] line_max;
  logic [7:0] hw_cnt;
  logic [7:0] hw_last;
  logic [4:0] vw_cnt;
  logic [4:0] vw_last;
  logic [11:0] field_lines;
  logic [11:0] prev_field;
  logic second_half;
  logic pseudo_seen;
  logic [11:0] stat_lines;
  logic [11:0] stat_clocks;
  logic [7:0] stat_hw;
  logic [4:0] stat_vw;
  logic stat_prog;
  logic stat_pseudo;

  logic [11:0] next_line_cnt;
  logic [11:0] next_line_max;
  logic [7:0] next_hw_cnt;
  logic [7:0] next_hw_last;
  logic [4:0] next_vw_cnt;
  logic [4:0] next_vw_last;
  logic [11:0] next_field_lines;
  logic [11:0] next_prev_field;
  logic next_second_half;
  logic next_pseudo_seen;
  logic [11:0] next_stat_lines;
  logic [11:0] next_stat_clocks;
  logic [7:0] next_stat_hw;
  logic [4:0] next_stat_vw;
  logic next_stat_prog;
  logic next_stat_pseudo;

  // active sense follows the detected polarity
  assign h_act = pins_s[0] ~^ hsync_active_high_i;
  assign v_act = pins_s[1] ~^ vsync_active_high_i;

  always_comb begin
    logic interlaced;
    logic frame_done;
    logic [12:0] limit;
    interlaced = 1'b0;
    frame_done = 1'b0;
    limit = 13'h0000;
    next_line_cnt = line_cnt;
    next_line_max = line_max;
    next_hw_cnt = hw_cnt;
    next_hw_last = hw_last;
    next_vw_cnt = vw_cnt;
    next_vw_last = vw_last;
    next_field_lines = field_lines;
    next_prev_field = prev_field;
    next_second_half = second_half;
    next_pseudo_seen = pseudo_seen;
    next_stat_lines = stat_lines;
    next_stat_clocks = stat_clocks;
    next_stat_hw = stat_hw;
    next_stat_vw = stat_vw;
    next_stat_prog = stat_prog;
    next_stat_pseudo = stat_pseudo;

    if (ref_tick) begin
      if (line_cnt != 12'hFFF) next_line_cnt = line_cnt + 12'h001;
      if (h_act && hw_cnt != 8'hFF) next_hw_cnt = hw_cnt + 8'h01;
    end
    if (!h_act && h_act_d) next_hw_last = hw_cnt;

    if (h_act && !h_act_d) begin
      // longest line, a new maximum must beat it by the tolerance
      limit = {1'b0, line_max} + {6'h00, tol};
      if ({1'b0, line_cnt} > limit) next_line_max = line_cnt;
      // a line under half the last frame's longest line, less half the tolerance, outside vsync is a pseudo-sync
      if (!v_act && stat_clocks != 12'h000 &&
          ({line_cnt, 1'b0} + {6'h00, tol}) < {1'b0, stat_clocks}) begin
        next_pseudo_seen = 1'b1;
      end
      next_line_cnt = 12'h000;
      next_hw_cnt = 8'h00;
      if (field_lines != 12'hFFF) next_field_lines = field_lines + 12'h001;
      // lines counted while vsync is active
      if (v_act && vw_cnt != 5'h1F) next_vw_cnt = vw_cnt + 5'h01;
    end
    if (!v_act && v_act_d) next_vw_last = vw_cnt;

    if (v_act && !v_act_d) begin
      next_vw_cnt = 5'h00;
      // fields alternating by one line mean interlace
      interlaced = (field_lines == prev_field + 12'h001) ||
                   (prev_field == field_lines + 12'h001);
      if (!interlaced) begin
        frame_done = 1'b1;
        next_second_half = 1'b0;
        next_stat_lines = field_lines;
      end else begin
        frame_done = second_half;
        next_second_half = ~second_half;
        next_stat_lines = second_half ? 12'(field_lines + prev_field) : stat_lines;
      end
      next_prev_field = field_lines;
      next_field_lines = 12'h000;
      // all status latched together at frame end
      if (frame_done) begin
        next_stat_prog = ~interlaced;
        next_stat_clocks = next_line_max;
        next_stat_hw = next_hw_last;
        next_stat_vw = vw_last;
        next_stat_pseudo = next_pseudo_seen;
        next_line_max = 12'h000;
        next_pseudo_seen = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      h_act_d <= 1'b0;
      v_act_d <= 1'b0;
      line_cnt <= 12'h000;
      line_max <= 12'h000;
      hw_cnt <= 8'h00;
      hw_last <= 8'h00;
      vw_cnt <= 5'h00;
      vw_last <= 5'h00;
      field_lines <= 12'h000;
      prev_field <= 12'h000;
      second_half <= 1'b0;
      pseudo_seen <= 1'b0;
      stat_lines <= 12'h000;
      stat_clocks <= 12'h000;
      stat_hw <= 8'h00;
      stat_vw <= 5'h00;
      stat_prog <= 1'b0;
      stat_pseudo <= 1'b0;
    end else begin
      h_act_d <= h_act;
      v_act_d <= v_act;
      line_cnt <= next_line_cnt;
      line_max <= next_line_max;
      hw_cnt <= next_hw_cnt;
      hw_last <= next_hw_last;
      vw_cnt <= next_vw_cnt;
      vw_last <= next_vw_last;
      field_lines <= next_field_lines;
      prev_field <= next_prev_field;
      second_half <= next_second_half;
      pseudo_seen <= next_pseudo_seen;
      stat_lines <= next_stat_lines;
      stat_clocks <= next_stat_clocks;
      stat_hw <= next_stat_hw;
      stat_vw <= next_stat_vw;
      stat_prog <= next_stat_prog;
      stat_pseudo <= next_stat_pseudo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        sync_meas_pkg::ADDR_PASSTHROUGH_CTL: next_rdata = {4'h0, ctl};
        sync_meas_pkg::ADDR_FRAME_LINES_LO: next_rdata = stat_lines[7:0];
        sync_meas_pkg::ADDR_FRAME_LINES_HI:
          next_rdata = {1'b0, stat_pseudo, stat_prog, 1'b0, stat_lines[11:8]};
        sync_meas_pkg::ADDR_LINE_CLOCKS_LO: next_rdata = stat_clocks[7:0];
        sync_meas_pkg::ADDR_LINE_CLOCKS_HI: next_rdata = {4'h0, stat_clocks[11:8]};
        sync_meas_pkg::ADDR_HSYNC_LENGTH: next_rdata = stat_hw;
        sync_meas_pkg::ADDR_VSYNC_LENGTH: next_rdata = {3'h0, stat_vw};
        sync_meas_pkg::ADDR_LINE_TOLERANCE: next_rdata = {1'b0, tol};
        sync_meas_pkg::ADDR_RESERVED_FIXED: next_rdata = rsv;
        sync_meas_pkg::ADDR_BANDWIDTH_CTL: next_rdata = {4'h0, bw};
        // unmapped reads give zero
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule

// ### tb/sync_measure_and_bypass_checker.sv
// checker for sync passthrough outputs and the register port
// assumes it is bound into sync_measure_and_bypass and sees only its ports
`timescale 1ns/1ps
module sync_measure_and_bypass_checker (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic hsync_in_i,
  input wire logic vsync_in_i,
  input wire logic proc_hsync_i,
  input wire logic proc_vsync_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic hsync_o,
  input wire logic vsync_o,
  input wire logic vert_horiz_output_offset_enable_o,
  input wire logic [3:0] analog_filter_select_o
);
  logic [3:0] ctl, next_ctl, bw, next_bw;
  logic [2:0] up, next_up;
  logic ok;
  ////////////////////////////////////////
  // shadow control bytes; up waits out the synchroniser after reset
  always_comb begin
    next_ctl = ctl;
    next_bw = bw;
    next_up = (up == 3'h4) ? up : up + 3'h1;
    if (reg_wr_i && reg_addr_i == sync_meas_pkg::ADDR_PASSTHROUGH_CTL)
      next_ctl = reg_wdata_i[3:0];
    if (reg_wr_i && reg_addr_i == sync_meas_pkg::ADDR_BANDWIDTH_CTL)
      next_bw = reg_wdata_i[3:0];
    if (sys_rst_i) begin
      next_ctl = 4'h0;
      next_bw = 4'h0;
      next_up = 3'h0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    ctl <= next_ctl;
    bw <= next_bw;
    up <= next_up;
  end
  assign ok = (up == 3'h4);
  ////////////////////////////////////////
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_hs_pass;
    ok && $past(ctl[0]) |-> hsync_o == ($past(hsync_in_i, 3) ^ $past(ctl[2]));
  endproperty
  a_hs_pass: assert property (p_hs_pass) else $error("raw hsync path wrong");
  property p_vs_pass;
    ok && $past(ctl[1]) |-> vsync_o == ($past(vsync_in_i, 3) ^ $past(ctl[3]));
  endproperty
  a_vs_pass: assert property (p_vs_pass) else $error("raw vsync path wrong");
  property p_hs_norm;
    ok && !$past(ctl[0]) |-> hsync_o == $past(proc_hsync_i);
  endproperty
  a_hs_norm: assert property (p_hs_norm) else $error("processed hsync path wrong");
  property p_vs_norm;
    ok && !$past(ctl[1]) |-> vsync_o == $past(proc_vsync_i);
  endproperty
  a_vs_norm: assert property (p_vs_norm) else $error("processed vsync path wrong");
  property p_offset;
    ok |-> vert_horiz_output_offset_enable_o == !($past(ctl[0]) || $past(ctl[1]));
  endproperty
  a_offset: assert property (p_offset) else $error("offset enable wrong");
  property p_filter;
    ok |-> analog_filter_select_o == $past(bw);
  endproperty
  a_filter: assert property (p_filter) else $error("filter select wrong");
  property p_rd_unmapped;
    reg_rd_i && (reg_addr_i < 8'h36 || reg_addr_i > 8'h3F) |=> reg_rdata_o == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_ctl;
    reg_rd_i && !reg_wr_i && reg_addr_i == 8'h36 |=> reg_rdata_o == {4'h0, $past(ctl)};
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
endmodule

bind sync_measure_and_bypass sync_measure_and_bypass_checker i_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsync_in_i(hsync_in_i),
  .vsync_in_i(vsync_in_i), .proc_hsync_i(proc_hsync_i), .proc_vsync_i(proc_vsync_i),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .hsync_o(hsync_o), .vsync_o(vsync_o),
  .vert_horiz_output_offset_enable_o(vert_horiz_output_offset_enable_o),
  .analog_filter_select_o(analog_filter_select_o));

// ### tb/sync_source_model.sv
// sync source: raw active-high sync pins and an external reference clock
// assumes the bench changes run_i and interlace_i between measurements only
`timescale 1ns/1ps
module sync_source_model #(
  parameter int LINE_LEN = 200,
  parameter int HS_LEN = 40,
  parameter int LINES = 16,
  parameter int VS_LINES = 3
) (
  input wire logic clk_sys_i,
  input wire logic run_i,
  input wire logic interlace_i,
  output logic hsync_o,
  output logic vsync_o,
  output logic ext_ref_o,
  output logic [15:0] field_cnt_o
);
  initial begin
    ext_ref_o = 1'b0;
    #7;
    forever #20 ext_ref_o = ~ext_ref_o;
  end
  initial begin
    hsync_o = 1'b0;
    vsync_o = 1'b0;
    field_cnt_o = 16'h0000;
    forever begin
      @(posedge clk_sys_i);
      while (run_i) begin
        // odd interlaced fields carry one extra line
        for (int n = 0; n < LINES + int'(interlace_i & field_cnt_o[0]); n++) begin
          #1 hsync_o = 1'b1;
          repeat (HS_LEN) @(posedge clk_sys_i);
          #1 hsync_o = 1'b0;
          // vsync moves mid-line so no line edge is ambiguous
          if (n == 0) vsync_o = 1'b1;
          if (n == VS_LINES) vsync_o = 1'b0;
          repeat (LINE_LEN - HS_LEN) @(posedge clk_sys_i);
        end
        field_cnt_o = field_cnt_o + 16'h0001;
      end
    end
  end
endmodule

// ### tb/sync_measure_and_bypass_bench.sv
// testbench: register port, sync passthrough and sync measurement
// assumes the source model owns the sync pins once measuring starts
`timescale 1ns/1ps
module sync_measure_and_bypass_bench;
  localparam int LL = 200;
  localparam int HL = 40;
  localparam int NL = 16;
  localparam int VL = 3;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic b_hs = 1'b0, b_vs = 1'b0, m_hs, m_vs, external_ref_clock_in, run = 1'b0, il = 1'b0;
  logic ref_ext = 1'b0, p_hs = 1'b0, p_vs = 1'b0, rd = 1'b0, wr = 1'b0, pol = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, v;
  logic hs_o, vs_o, off_en;
  logic [3:0] filt;
  logic [15:0] fields;
  logic [7:0] tol [4] = '{8'h00, 8'h06, 8'h7F, 8'h03};
  integer seed = 32'h9EF0;
  int err_count = 0;
  int checks = 0;
  // with pol low the pins carry active-low syncs, so the polarity inputs are exercised
  wire logic hs_pin = run ? (m_hs ~^ pol) : b_hs;
  wire logic vs_pin = run ? (m_vs ~^ pol) : b_vs;
  sync_measure_and_bypass i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .hsync_in_i(hs_pin), .vsync_in_i(vs_pin), .external_ref_clock_in_i(external_ref_clock_in),
    .ref_clock_external_i(ref_ext), .hsync_active_high_i(pol), .vsync_active_high_i(pol),
    .proc_hsync_i(p_hs), .proc_vsync_i(p_vs), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .hsync_o(hs_o), .vsync_o(vs_o),
    .vert_horiz_output_offset_enable_o(off_en), .analog_filter_select_o(filt));
  sync_source_model #(.LINE_LEN(LL), .HS_LEN(HL), .LINES(NL), .VS_LINES(VL)) i_src (
    .clk_sys_i(clk_sys_i), .run_i(run), .interlace_i(il), .hsync_o(m_hs), .vsync_o(m_vs),
    .ext_ref_o(external_ref_clock_in), .field_cnt_o(fields));
  always #2 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input int slack);
    checks++;
    if ($isunknown(got) || got + slack < exp || got > exp + slack) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access, then an idle edge so strobes never rise in the step they fall
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] val);
    addr = a;
    wdata = val;
    wr = w;
    rd = !w;
    @(posedge clk_sys_i);
    #1 wr = 1'b0;
    rd = 1'b0;
    d = rdata;
    @(posedge clk_sys_i);
    #1;
  endtask
  // integer model: counts in reference ticks, sync jitter allows one tick
  task automatic measure(input logic ext, input logic ilace, input int div);
    int k;
    int tgt;
    int lines;
    logic [7:0] s [6];
    ref_ext = ext;
    il = ilace;
    run = 1'b1;
    tgt = fields + 6;
    lines = ilace ? 2 * NL + 1 : NL;
    for (k = 0; k < 40000 && fields < tgt; k++) @(posedge clk_sys_i);
    #1;
    if (k == 40000) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, fields, tgt);
      tally_and_finish();
    end
    for (k = 0; k < 6; k++) begin
      acc(1'b0, 8'(8'h37 + k), 8'h00);
      s[k] = d;
    end
    chk(12'({s[1][3:0], s[0]}), 12'(lines), 0);
    chk(12'(s[1][7:4]), ilace ? 12'h000 : 12'h002, 0);
    chk(12'({s[3][7:0]}), 12'h000, 0);
    chk(12'(s[2]), 12'(LL / div), 1);
    // line period rebuilt from the count, as host software would
    chk(12'(int'(s[2]) * div), 12'(LL), div);
    chk(12'(s[4]), 12'(HL / div), 1);
    chk(12'(s[5]), 12'(VL), 0);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    for (int a = 8'h35; a <= 8'h40; a++) begin
      acc(1'b0, 8'(a), 8'h00);
      chk(12'(d), a == 8'h3D ? 12'h003 : a == 8'h3E ? 12'h004 : 12'h000, 0);
      // the reserved byte only ever gets its required setting
      v = (a == 8'h3E) ? 8'h04 : 8'($random(seed));
      acc(1'b1, 8'(a), v);
      acc(1'b0, 8'(a), 8'h00);
      chk(12'(d), 12'(a == 8'h3E ? v : a == 8'h3D ? v & 8'h7F :
        (a == 8'h36 || a == 8'h3F) ? v & 8'h0F : 8'h00), 0);
    end
    foreach (tol[i]) begin
      acc(1'b1, 8'h3D, tol[i]);
      acc(1'b0, 8'h3D, 8'h00);
      chk(12'(d), 12'(tol[i]), 0);
    end
    for (int c = 0; c < 16; c++) begin
      acc(1'b1, 8'h36, 8'(c) | 8'hF0);
      acc(1'b0, 8'h36, 8'h00);
      chk(12'(d), 12'(c), 0);
      repeat (6) begin
        {b_hs, b_vs, p_hs, p_vs} = 4'($random(seed));
        @(posedge clk_sys_i);
        #1;
      end
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk(12'(hs_o), 12'(c[0] ? b_hs ^ c[2] : p_hs), 0);
      chk(12'(vs_o), 12'(c[1] ? b_vs ^ c[3] : p_vs), 0);
      chk(12'(off_en), 12'(!(c[0] | c[1])), 0);
      v = 8'($random(seed));
      acc(1'b1, 8'h3F, v);
      chk(12'(filt), 12'(v[3:0]), 0);
    end
    measure(1'b0, 1'b0, int'(sync_meas_pkg::INT_REF_DIV));
    pol = 1'b0;
    measure(1'b1, 1'b1, 10);
    acc(1'b1, 8'h37, 8'hFF);
    acc(1'b0, 8'h37, 8'h00);
    chk(12'(d), 12'(2 * NL + 1), 0);
    tally_and_finish();
  end
endmodule
